// ===== src/hart_debug_trigger_csrs.sv
// per-hart debug csrs and indirect trigger register banks
`timescale 1ns/100ps
`default_nettype none
`include "dbg_trig_cfg.svh"
module hart_debug_trigger_csrs (
  input wire logic clock,
  input wire logic srst,
  input wire dbg_trig_pkg::csr_req_t csr_req,
  input wire logic [1:0] priv_mode,
  input wire logic dbg_enter,
  input wire logic [31:0] dbg_enter_pc,
  input wire logic dbg_exit,
  output var dbg_trig_pkg::csr_rsp_t csr_rsp,
  output logic in_debug,
  output logic resume_valid,
  output logic [31:0] resume_pc
);
  localparam int NT = `DT_NUM_TRIG;

  function automatic dbg_trig_pkg::csr_kind_t csr_kind(input logic [11:0] a);
    case (a)
      `DT_ADDR_TSEL: csr_kind = dbg_trig_pkg::K_TSEL;
      `DT_ADDR_TRIG_D1: csr_kind = dbg_trig_pkg::K_TD1;
      `DT_ADDR_TRIG_D2: csr_kind = dbg_trig_pkg::K_TD2;
      `DT_ADDR_TRIG_D3: csr_kind = dbg_trig_pkg::K_TD3;
      `DT_ADDR_DCSR: csr_kind = dbg_trig_pkg::K_DCSR;
      `DT_ADDR_DPC: csr_kind = dbg_trig_pkg::K_DPC;
      `DT_ADDR_DSCRATCH: csr_kind = dbg_trig_pkg::K_DSCR;
      default: csr_kind = dbg_trig_pkg::K_NONE;
    endcase
  endfunction : csr_kind

  // only implemented banks report a trigger kind
  function automatic logic [3:0] trig_type(input logic idx);
    trig_type = (32'(idx) < NT) ? `DT_TYPE_MATCH : `DT_TYPE_NONE;
  endfunction : trig_type

  logic tsel_ff, nxt_tsel;
  logic [27:0] td1_ff [NT];
  logic [27:0] nxt_td1 [NT];
  logic [31:0] td2_ff [NT];
  logic [31:0] nxt_td2 [NT];
  logic [31:0] td3_ff [NT];
  logic [31:0] nxt_td3 [NT];
  logic [31:0] dcsr_ff, nxt_dcsr, dpc_ff, nxt_dpc, dscr_ff, nxt_dscr;
  logic dbg_ff, nxt_dbg, resv_ff, nxt_resv;
  logic [31:0] rpc_ff, nxt_rpc;
  dbg_trig_pkg::csr_rsp_t rsp_ff, nxt_rsp;

  dbg_trig_pkg::csr_kind_t kind;
  logic is_trig, is_tdata, is_dbg_only, sel_dmode, illegal, do_wr;
  logic [31:0] rd;

  always_comb begin
    kind = csr_kind(csr_req.addr);
    is_trig = kind inside {dbg_trig_pkg::K_TSEL, dbg_trig_pkg::K_TD1,
                           dbg_trig_pkg::K_TD2, dbg_trig_pkg::K_TD3};
    is_tdata = is_trig && kind != dbg_trig_pkg::K_TSEL;
    is_dbg_only = kind inside {dbg_trig_pkg::K_DCSR, dbg_trig_pkg::K_DPC,
                               dbg_trig_pkg::K_DSCR};
    sel_dmode = td1_ff[tsel_ff][`DT_DMODE_BIT];
    illegal = 1'b1;
    if (is_dbg_only) begin
      illegal = !dbg_ff;
    end else if (is_trig) begin
      illegal = !dbg_ff && priv_mode != `DT_PRIV_M;
      if (is_tdata && !dbg_ff && sel_dmode) begin
        illegal = 1'b1;
      end
    end
    do_wr = csr_req.valid && csr_req.we && !illegal;
    // read view of the addressed csr, trigger data from the selected bank
    case (kind)
      dbg_trig_pkg::K_TSEL: rd = {31'h0000_0000, tsel_ff};
      dbg_trig_pkg::K_TD1:
        rd = {trig_type(tsel_ff), td1_ff[tsel_ff] | `DT_TD1_FIXED};
      dbg_trig_pkg::K_TD2: rd = td2_ff[tsel_ff];
      dbg_trig_pkg::K_TD3: rd = td3_ff[tsel_ff];
      dbg_trig_pkg::K_DCSR: rd = dcsr_ff;
      dbg_trig_pkg::K_DPC: rd = dpc_ff;
      dbg_trig_pkg::K_DSCR: rd = dscr_ff;
      default: rd = `DT_RST_WORD;
    endcase
  end

  always_comb begin
    nxt_tsel = tsel_ff;
    nxt_td1 = td1_ff;
    nxt_td2 = td2_ff;
    nxt_td3 = td3_ff;
    nxt_dcsr = dcsr_ff;
    nxt_dpc = dpc_ff;
    nxt_dscr = dscr_ff;
    nxt_dbg = dbg_ff;
    nxt_resv = 1'b0;
    nxt_rpc = rpc_ff;
    nxt_rsp.ack = csr_req.valid;
    nxt_rsp.illegal = csr_req.valid && illegal;
    nxt_rsp.rdata = (csr_req.valid && !illegal) ? rd : `DT_RST_WORD;
    if (do_wr) begin
      case (kind)
        dbg_trig_pkg::K_TSEL: begin
          // out-of-range index is dropped, the old one stays
          if (csr_req.wdata < 32'(NT)) begin
            nxt_tsel = csr_req.wdata[0];
          end
        end
        dbg_trig_pkg::K_TD1: begin
          // type and fixed fields are never stored; dmode settable only from debug mode
          nxt_td1[tsel_ff] = csr_req.wdata[27:0] & `DT_TD1_WMASK;
          if (!dbg_ff) begin
            nxt_td1[tsel_ff][`DT_DMODE_BIT] = 1'b0;
          end
        end
        dbg_trig_pkg::K_TD2: nxt_td2[tsel_ff] = csr_req.wdata;
        dbg_trig_pkg::K_TD3: nxt_td3[tsel_ff] = csr_req.wdata;
        dbg_trig_pkg::K_DCSR: nxt_dcsr = csr_req.wdata;
        dbg_trig_pkg::K_DPC: nxt_dpc = csr_req.wdata;
        dbg_trig_pkg::K_DSCR: nxt_dscr = csr_req.wdata;
        default: nxt_dscr = dscr_ff;
      endcase
    end
    // entry wins over a same-cycle csr write to the debug pc
    if (dbg_enter && !dbg_ff) begin
      nxt_dbg = 1'b1;
      nxt_dpc = dbg_enter_pc;
    end else if (dbg_exit && dbg_ff) begin
      nxt_dbg = 1'b0;
      nxt_resv = 1'b1;
      nxt_rpc = dpc_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tsel_ff <= `DT_RST_IDX;
      for (int i = 0; i < NT; i++) begin
        td1_ff[i] <= `DT_RST_TD1;
        td2_ff[i] <= `DT_RST_WORD;
        td3_ff[i] <= `DT_RST_WORD;
      end
      dcsr_ff <= `DT_RST_WORD;
      dpc_ff <= `DT_RST_WORD;
      dscr_ff <= `DT_RST_WORD;
      dbg_ff <= 1'b0;
      resv_ff <= 1'b0;
      rpc_ff <= `DT_RST_WORD;
      rsp_ff <= '0;
    end else begin
      tsel_ff <= nxt_tsel;
      td1_ff <= nxt_td1;
      td2_ff <= nxt_td2;
      td3_ff <= nxt_td3;
      dcsr_ff <= nxt_dcsr;
      dpc_ff <= nxt_dpc;
      dscr_ff <= nxt_dscr;
      dbg_ff <= nxt_dbg;
      resv_ff <= nxt_resv;
      rpc_ff <= nxt_rpc;
      rsp_ff <= nxt_rsp;
    end
  end

  assign csr_rsp = rsp_ff;
  assign in_debug = dbg_ff;
  assign resume_valid = resv_ff;
  assign resume_pc = rpc_ff;

  sequence s_scr_wr;
    csr_req.valid && csr_req.we && kind == dbg_trig_pkg::K_DSCR && dbg_ff;
  endsequence
  sequence s_scr_rd;
    csr_req.valid && !csr_req.we && kind == dbg_trig_pkg::K_DSCR && dbg_ff;
  endsequence
  sequence s_leave;
    dbg_exit && dbg_ff && !dbg_enter;
  endsequence

  property p_dbg_only;
    @(posedge clock) disable iff (srst)
    csr_req.valid && is_dbg_only && !dbg_ff |=> csr_rsp.ack && csr_rsp.illegal;
  endproperty
  a_dbg_only: assert property (p_dbg_only) else $error("debug-only csr reached outside debug");

  property p_trig_access;
    @(posedge clock) disable iff (srst)
    csr_req.valid && kind == dbg_trig_pkg::K_TSEL && priv_mode == `DT_PRIV_M
      |=> csr_rsp.ack && !csr_rsp.illegal;
  endproperty
  a_trig_access: assert property (p_trig_access) else $error("select refused in machine mode");

  property p_tsel_legal;
    @(posedge clock) disable iff (srst)
    csr_req.valid && kind == dbg_trig_pkg::K_TSEL && !illegal && !csr_req.we
      |=> csr_rsp.rdata < 32'(NT);
  endproperty
  a_tsel_legal: assert property (p_tsel_legal) else $error("select holds bad index");

  property p_tsel_keep;
    @(posedge clock) disable iff (srst)
    do_wr && kind == dbg_trig_pkg::K_TSEL && csr_req.wdata >= 32'(NT) |=> $stable(tsel_ff);
  endproperty
  a_tsel_keep: assert property (p_tsel_keep) else $error("bad index not dropped");

  property p_type;
    @(posedge clock) disable iff (srst)
    csr_req.valid && kind == dbg_trig_pkg::K_TD1 && !illegal
      |=> csr_rsp.rdata[31:28] == `DT_TYPE_MATCH;
  endproperty
  a_type: assert property (p_type) else $error("type code wrong");

  property p_dmode_illegal;
    @(posedge clock) disable iff (srst)
    csr_req.valid && is_tdata && !dbg_ff && sel_dmode |=> csr_rsp.illegal && csr_rsp.rdata == 0;
  endproperty
  a_dmode_illegal: assert property (p_dmode_illegal) else $error("debug view leaked");

  property p_dpc_capture;
    @(posedge clock) disable iff (srst)
    dbg_enter && !dbg_ff |=> in_debug && dpc_ff == $past(dbg_enter_pc);
  endproperty
  a_dpc_capture: assert property (p_dpc_capture) else $error("debug pc not captured");

  property p_resume;
    @(posedge clock) disable iff (srst)
    s_leave |=> resume_valid && !in_debug && resume_pc == $past(dpc_ff) ##1 !resume_valid;
  endproperty
  a_resume: assert property (p_resume) else $error("resume pc wrong");

  property p_scratch;
    @(posedge clock) disable iff (srst)
    s_scr_wr ##1 s_scr_rd |=> csr_rsp.rdata == $past(csr_req.wdata, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch lost its value");
endmodule : hart_debug_trigger_csrs
`default_nettype wire

// ===== src/dbg_trig_cfg.svh
// addresses, field positions, reset values for the hart debug/trigger csr block
`ifndef DBG_TRIG_CFG_SVH
`define DBG_TRIG_CFG_SVH
`define DT_ADDR_TSEL 12'h07a0
`define DT_ADDR_TRIG_D1 12'h07a1
`define DT_ADDR_TRIG_D2 12'h07a2
`define DT_ADDR_TRIG_D3 12'h07a3
`define DT_ADDR_DCSR 12'h07b0
`define DT_ADDR_DPC 12'h07b1
`define DT_ADDR_DSCRATCH 12'h07b2
`define DT_NUM_TRIG 2
`define DT_PRIV_M 2'h3
`define DT_TYPE_LSB 28
`define DT_DMODE_BIT 27
`define DT_TYPE_NONE 4'h0
`define DT_TYPE_MATCH 4'h2
`define DT_TD1_WMASK 28'h800_ffdf
`define DT_TD1_FIXED 28'h080_0000
`define DT_RST_WORD 32'h0000_0000
`define DT_RST_TD1 28'h000_0000
`define DT_RST_IDX 1'h0
`endif

// ===== src/dbg_trig_pkg.sv
// types for the hart debug/trigger csr block
package dbg_trig_pkg;
  typedef struct packed {
    logic valid;
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_t;
  typedef struct packed {
    logic ack;
    logic illegal;
    logic [31:0] rdata;
  } csr_rsp_t;
  typedef enum logic [7:0] {
    K_NONE = 8'h01,
    K_TSEL = 8'h02,
    K_TD1 = 8'h04,
    K_TD2 = 8'h08,
    K_TD3 = 8'h10,
    K_DCSR = 8'h20,
    K_DPC = 8'h40,
    K_DSCR = 8'h80
  } csr_kind_t;
endpackage : dbg_trig_pkg

// ===== sim/pipe_model.sv
// pipeline-side model: issues csr accesses and debug entry or exit
`timescale 1ns/100ps
`default_nettype none
module pipe_model (
  input wire logic clock,
  output var dbg_trig_pkg::csr_req_t req,
  output logic [1:0] priv,
  output logic enter,
  output logic [31:0] enter_pc,
  output logic leave
);
  initial begin
    req = '0;
    priv = 2'h3;
    enter = 1'b0;
    enter_pc = 32'h0000_0000;
    leave = 1'b0;
  end
  // one cycle per call; idle address, data and entry pc lines get fresh junk so stale data cannot pass
  task automatic drive(input logic v, input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [1:0] p, input logic e, input logic x,
      input logic [31:0] pc);
    @(negedge clock);
    req.valid = v;
    req.we = v & w;
    req.addr = v ? a : 12'($urandom);
    req.wdata = v ? d : $urandom;
    priv = p;
    enter = e;
    enter_pc = e ? pc : $urandom;
    leave = x;
  endtask : drive
endmodule : pipe_model
`default_nettype wire

// ===== sim/hart_debug_trigger_csrs_tb.sv
// self-checking bench for the hart debug/trigger csr block
`timescale 1ns/100ps
`default_nettype none
`include "dbg_trig_cfg.svh"
module hart_debug_trigger_csrs_tb;
  localparam logic [11:0] ad_sel = `DT_ADDR_TSEL;
  localparam logic [11:0] ad_td1 = `DT_ADDR_TRIG_D1;
  localparam logic [11:0] ad_td2 = `DT_ADDR_TRIG_D2;
  localparam logic [11:0] ad_td3 = `DT_ADDR_TRIG_D3;
  localparam logic [1:0] pm = `DT_PRIV_M;
  logic clock = 1'b0;
  logic srst = 1'b1;
  dbg_trig_pkg::csr_req_t csr_req;
  dbg_trig_pkg::csr_rsp_t csr_rsp;
  logic [1:0] priv_mode;
  logic dbg_enter, dbg_exit, in_debug, resume_valid;
  logic [31:0] dbg_enter_pc, resume_pc, r0, r1;
  logic [33:0] expq[$];
  logic [33:0] e;
  int miscompares = 0;
  int num_checks = 0;
  always #2.5 clock = ~clock;
  pipe_model pipe_model_i (.clock, .req(csr_req), .priv(priv_mode), .enter(dbg_enter),
    .enter_pc(dbg_enter_pc), .leave(dbg_exit));
  hart_debug_trigger_csrs hart_debug_trigger_csrs_i (.clock, .srst, .csr_req, .priv_mode,
    .dbg_enter, .dbg_enter_pc, .dbg_exit, .csr_rsp, .in_debug, .resume_valid, .resume_pc);
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // legal write answers carry the old read view, so only their illegal flag is noted
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] p, input logic ill, input logic [31:0] x);
    expq.push_back({~w | ill, ill, ill ? 32'h0000_0000 : x});
    pipe_model_i.drive(1'b1, w, a, d, p, 1'b0, 1'b0, 32'h0000_0000);
  endtask : acc
  task automatic link(input logic en, input logic ex, input logic [31:0] pc, input logic [31:0] rp);
    pipe_model_i.drive(1'b0, 1'b0, 12'h000, 32'h0000_0000, pm, en, ex, pc);
    pipe_model_i.drive(1'b0, 1'b0, 12'h000, 32'h0000_0000, pm, 1'b0, 1'b0, 32'h0000_0000);
    check("in_debug", {32'h0000_0000, in_debug}, {32'h0000_0000, en});
    check("resume", {resume_valid, resume_pc}, {ex, rp});
  endtask : link
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  always @(negedge clock) begin
    if (csr_rsp.ack === 1'b1) begin
      if (expq.size() == 0) begin
        check("spurious ack", 33'h1_0000_0000, 33'h0_0000_0000);
      end else begin
        e = expq.pop_front();
        check("csr answer", {csr_rsp.illegal, e[33] ? csr_rsp.rdata : e[31:0]}, e[32:0]);
      end
    end
  end
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(62370));
    r0 = $urandom;
    r1 = $urandom;
    repeat (4) @(negedge clock);
    srst = 1'b0;
    acc(0, ad_td1, 0, pm, 0, 32'h2080_0000);
    acc(0, ad_sel, 0, pm, 0, 32'h0000_0000);
    acc(1, ad_sel, 1, pm, 0, 0);
    acc(0, ad_sel, 0, pm, 0, 32'h0000_0001);
    acc(1, ad_sel, 5, pm, 0, 0);
    acc(1, ad_sel, 32'h0000_0002, pm, 0, 0);
    acc(0, ad_sel, 0, pm, 0, 32'h0000_0001);
    $display("test select done");
    acc(1, ad_td2, r1, pm, 0, 0);
    acc(1, ad_sel, 0, pm, 0, 0);
    acc(1, ad_td2, r0, pm, 0, 0);
    acc(1, ad_td3, ~r0, pm, 0, 0);
    acc(1, ad_td1, 32'hffff_ffff, pm, 0, 0);
    acc(0, ad_td1, 0, pm, 0, 32'h2080_ffdf);
    acc(0, ad_td2, 0, pm, 0, r0);
    acc(0, ad_td3, 0, pm, 0, ~r0);
    acc(1, ad_sel, 1, pm, 0, 0);
    acc(0, ad_td2, 0, pm, 0, r1);
    acc(0, ad_td1, 0, pm, 0, 32'h2080_0000);
    $display("test banks done");
    acc(0, ad_sel, 0, 2'h0, 1, 0);
    acc(0, `DT_ADDR_DSCRATCH, 0, pm, 1, 0);
    acc(1, `DT_ADDR_DPC, r0, pm, 1, 0);
    acc(0, 12'h0123, 0, pm, 1, 0);
    $display("test access modes done");
    link(1, 0, r0, 32'h0000_0000);
    acc(0, `DT_ADDR_DPC, 0, pm, 0, r0);
    acc(1, `DT_ADDR_DSCRATCH, r1, 2'h0, 0, 0);
    acc(0, `DT_ADDR_DSCRATCH, 0, 2'h0, 0, r1);
    acc(0, `DT_ADDR_DCSR, 0, pm, 0, 32'h0000_0000);
    acc(1, `DT_ADDR_DCSR, r0, pm, 0, 32'h0000_0000);
    acc(0, `DT_ADDR_DCSR, 32'h0000_0000, pm, 0, r0);
    acc(1, `DT_ADDR_DPC, ~r1, pm, 0, 0);
    // entry while already in debug must not recapture the pc
    link(1, 0, r0, 32'h0000_0000);
    acc(1, ad_td1, 32'h0800_0000, pm, 0, 0);
    acc(0, ad_td1, 0, pm, 0, 32'h2880_0000);
    link(0, 1, 0, ~r1);
    acc(0, ad_td1, 0, pm, 1, 0);
    acc(1, ad_td2, r0, pm, 1, 0);
    acc(0, ad_td3, 0, pm, 1, 0);
    acc(1, ad_sel, 0, pm, 0, 0);
    acc(0, ad_td1, 0, pm, 0, 32'h2080_ffdf);
    acc(0, `DT_ADDR_DSCRATCH, 0, pm, 1, 0);
    $display("test debug mode done");
    pipe_model_i.drive(0, 0, 12'h000, 0, pm, 0, 0, 0);
    repeat (3) @(negedge clock);
    if (expq.size() != 0) check("missing ack", 33'h1_0000_0000, 33'h0_0000_0000);
    end_of_test();
  end
endmodule : hart_debug_trigger_csrs_tb
`default_nettype wire
